/* File: src/ocmux_cfg.svh */
// constants of the eight-way channel multiplexer: layout, reset values, address
`ifndef OCMUX_CFG_SVH
`define OCMUX_CFG_SVH

`define OCMUX_CHANNELS 8
`define OCMUX_CTRL_WIDTH 8
`define OCMUX_CTRL_RESET 8'h08
`define OCMUX_ENABLE_BIT 3
`define OCMUX_INDEX_MSB 2
`define OCMUX_INDEX_LSB 0
// fixed upper address bits; the value is arbitrary
`define OCMUX_ADDR_HI_DEFAULT 4'ha
`define OCMUX_ADDR_WIDTH 7
`define OCMUX_LAST_BIT 3'h7
`define OCMUX_DIR_READ 1'b1
`define OCMUX_SYNC_RESET 3'h0

`endif

/* File: src/ocmux_pkg.sv */
// types shared by the channel multiplexer modules
package ocmux_pkg;

    typedef enum logic [2:0] {
        OCMUX_IDLE,
        OCMUX_ADDR,
        OCMUX_ADDR_ACK,
        OCMUX_WR_DATA,
        OCMUX_WR_ACK,
        OCMUX_RD_DATA,
        OCMUX_RD_ACK
    } ocmux_state_type;

    typedef logic [7:0] ocmux_ctrl_type;

endpackage

/* File: src/ocmux_link_if.sv */
// carrier between the link-clock sampler and the core logic
`timescale 1ns/1ps
interface ocmux_link_if;
    logic rise_toggle;
    logic rise_bit;

    modport sampler (output rise_toggle, output rise_bit);
    modport core (input rise_toggle, input rise_bit);
endinterface

/* File: src/ocmux_link_sampler.sv */
// link-clock domain: captures the data line on each rising serial clock edge
`timescale 1ns/1ps
module ocmux_link_sampler (
    input wire logic link_clk,
    input wire logic rst_n,
    input wire logic data_in,
    ocmux_link_if.sampler link
);
    logic toggle_reg;
    logic bit_reg;

    // one toggle per rising edge; the bit stays stable for the whole clock period
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            toggle_reg <= 1'b0;
            bit_reg <= 1'b1;
        end else begin
            toggle_reg <= ~toggle_reg;
            bit_reg <= data_in;
        end
    end

    assign link.rise_toggle = toggle_reg;
    assign link.rise_bit = bit_reg;
endmodule

/* File: src/ocmux_top.sv */
// two-wire slave with one control byte steering one of eight downstream pairs
`timescale 1ns/1ps
`include "ocmux_cfg.svh"

module ocmux_top #(
    parameter logic [3:0] ADDR_HI = `OCMUX_ADDR_HI_DEFAULT,
    parameter int CHANNELS = `OCMUX_CHANNELS
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic SCL,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_N,
    input wire logic ADDR_STRAP_BIT0,
    input wire logic ADDR_STRAP_BIT1,
    input wire logic ADDR_STRAP_BIT2,
    output logic [CHANNELS-1:0] DOWNSTREAM_CLOCK_O,
    output logic [CHANNELS-1:0] DOWNSTREAM_CLOCK_OE_N,
    output logic [CHANNELS-1:0] DOWNSTREAM_DATA_O,
    output logic [CHANNELS-1:0] DOWNSTREAM_DATA_OE_N
);

    ocmux_link_if link ();

    // rising serial clock edges are caught on the link clock itself
    ocmux_link_sampler u_sampler (
        .link_clk (SCL),
        .rst_n (RST_N),
        .data_in (SDA_I),
        .link (link)
    );

    // true when the control byte asks for channel ch
    function automatic logic ocmux_selects(input logic [7:0] ctrl,
                                           input int ch);
        logic hit;
        hit = ctrl[`OCMUX_ENABLE_BIT] &&
              (ctrl[`OCMUX_INDEX_MSB:`OCMUX_INDEX_LSB] == ch[2:0]);
        return hit;
    endfunction

    // true when the received address byte names this instance
    function automatic logic ocmux_addr_match(input logic [7:0] rx,
                                              input logic [6:0] own);
        return rx[7:1] == own;
    endfunction

    // true when the direction bit of the address byte asks for a read
    function automatic logic ocmux_is_read(input logic [7:0] rx);
        return rx[0] == `OCMUX_DIR_READ;
    endfunction

    // oversampling at the system clock keeps up with a 400 kHz link
    // pin synchronisers: first stage feeds only the second
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic [1:0] tog_sync_reg;
    logic tog_seen_reg;
    logic tog_old_reg;
    logic [1:0] bit_sync_reg;
    logic [2:0] strap_meta_reg;
    logic [2:0] strap_reg;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            tog_sync_reg <= 2'h0;
            tog_seen_reg <= 1'b0;
            tog_old_reg <= 1'b0;
            bit_sync_reg <= 2'h3;
        end else if (CE) begin
            scl_sync_reg <= {scl_sync_reg[1:0], SCL};
            sda_sync_reg <= {sda_sync_reg[1:0], SDA_I};
            tog_sync_reg <= {tog_sync_reg[0], link.rise_toggle};
            tog_seen_reg <= tog_sync_reg[1];
            tog_old_reg <= tog_seen_reg;
            bit_sync_reg <= {bit_sync_reg[0], link.rise_bit};
        end
    end

    // straps read through two stages; they carry no internal pull
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            strap_meta_reg <= `OCMUX_SYNC_RESET;
            strap_reg <= `OCMUX_SYNC_RESET;
        end else if (CE) begin
            strap_meta_reg <= {ADDR_STRAP_BIT2, ADDR_STRAP_BIT1, ADDR_STRAP_BIT0};
            strap_reg <= strap_meta_reg;
        end
    end

    logic scl_high;
    logic scl_fall;
    logic scl_rise;
    logic rx_bit;
    logic start_seen;
    logic stop_seen;

    assign scl_high = scl_sync_reg[1] && scl_sync_reg[2];
    assign scl_fall = !scl_sync_reg[1] && scl_sync_reg[2];
    // a rise is acted on one cycle after its toggle, once the sampled bit has settled
    assign scl_rise = tog_seen_reg ^ tog_old_reg;
    assign rx_bit = bit_sync_reg[1];
    assign start_seen = scl_high && !sda_sync_reg[1] && sda_sync_reg[2];
    assign stop_seen = scl_high && sda_sync_reg[1] && !sda_sync_reg[2];

    ocmux_pkg::ocmux_state_type state_reg;
    logic [7:0] shift_reg;
    logic [2:0] count_reg;
    logic byte_done_reg;
    logic drive_low_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] applied_reg;
    logic pending_reg;

    // address of this instance: fixed high bits plus the straps
    logic [`OCMUX_ADDR_WIDTH-1:0] own_addr;
    assign own_addr = {ADDR_HI, strap_reg};

    // bit counter and shifter; bits arrive msb first
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            count_reg <= 3'h0;
            byte_done_reg <= 1'b0;
            shift_reg <= 8'h00;
        end else if (CE) begin
            if (start_seen) begin
                count_reg <= 3'h0;
                byte_done_reg <= 1'b0;
            end else if (scl_rise && (state_reg == ocmux_pkg::OCMUX_ADDR ||
                                      state_reg == ocmux_pkg::OCMUX_WR_DATA)) begin
                shift_reg <= {shift_reg[6:0], rx_bit};
                count_reg <= count_reg + 3'h1;
                byte_done_reg <= (count_reg == `OCMUX_LAST_BIT);
            end else if (scl_rise && state_reg == ocmux_pkg::OCMUX_RD_DATA) begin
                count_reg <= count_reg + 3'h1;
                byte_done_reg <= (count_reg == `OCMUX_LAST_BIT);
            end else if (scl_fall && state_reg == ocmux_pkg::OCMUX_RD_DATA &&
                         !byte_done_reg) begin
                shift_reg <= {shift_reg[6:0], 1'b1};
            end else if (scl_fall && state_reg == ocmux_pkg::OCMUX_ADDR_ACK) begin
                // read: load stored byte, all eight bits
                shift_reg <= ctrl_reg;
                count_reg <= 3'h0;
                byte_done_reg <= 1'b0;
            end else if (scl_fall && state_reg == ocmux_pkg::OCMUX_RD_ACK) begin
                shift_reg <= ctrl_reg;
                count_reg <= 3'h0;
                byte_done_reg <= 1'b0;
            end else if (scl_fall && state_reg == ocmux_pkg::OCMUX_WR_ACK) begin
                count_reg <= 3'h0;
                byte_done_reg <= 1'b0;
            end
        end
    end

    logic rd_nack_reg;

    // bus engine; a START restarts it from any state, a STOP ends it
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= ocmux_pkg::OCMUX_IDLE;
            rd_nack_reg <= 1'b0;
        end else if (CE) begin
            if (start_seen) begin
                state_reg <= ocmux_pkg::OCMUX_ADDR;
            end else if (stop_seen) begin
                state_reg <= ocmux_pkg::OCMUX_IDLE;
            end else begin
                case (state_reg)
                    ocmux_pkg::OCMUX_IDLE: begin
                        state_reg <= ocmux_pkg::OCMUX_IDLE;
                    end
                    ocmux_pkg::OCMUX_ADDR: begin
                        if (scl_fall && byte_done_reg) begin
                            if (ocmux_addr_match(shift_reg, own_addr)) begin
                                state_reg <= ocmux_pkg::OCMUX_ADDR_ACK;
                            end else begin
                                state_reg <= ocmux_pkg::OCMUX_IDLE;
                            end
                        end
                    end
                    ocmux_pkg::OCMUX_ADDR_ACK: begin
                        if (scl_fall) begin
                            if (ocmux_is_read(shift_reg)) begin
                                state_reg <= ocmux_pkg::OCMUX_RD_DATA;
                            end else begin
                                state_reg <= ocmux_pkg::OCMUX_WR_DATA;
                            end
                        end
                    end
                    ocmux_pkg::OCMUX_WR_DATA: begin
                        if (scl_fall && byte_done_reg) begin
                            state_reg <= ocmux_pkg::OCMUX_WR_ACK;
                        end
                    end
                    ocmux_pkg::OCMUX_WR_ACK: begin
                        if (scl_fall) begin
                            state_reg <= ocmux_pkg::OCMUX_WR_DATA;
                        end
                    end
                    ocmux_pkg::OCMUX_RD_DATA: begin
                        if (scl_fall && byte_done_reg) begin
                            state_reg <= ocmux_pkg::OCMUX_RD_ACK;
                        end
                    end
                    ocmux_pkg::OCMUX_RD_ACK: begin
                        if (scl_rise) begin
                            rd_nack_reg <= rx_bit;
                        end
                        if (scl_fall) begin
                            // master nack ends the read; wait for STOP
                            state_reg <= rd_nack_reg ? ocmux_pkg::OCMUX_IDLE :
                                                       ocmux_pkg::OCMUX_RD_DATA;
                        end
                    end
                    default: begin
                        state_reg <= ocmux_pkg::OCMUX_IDLE;
                    end
                endcase
            end
        end
    end

    // upstream data drive: acks and read bits; released otherwise
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            drive_low_reg <= 1'b0;
        end else if (CE) begin
            if (start_seen || stop_seen) begin
                drive_low_reg <= 1'b0;
            end else if (scl_fall) begin
                case (state_reg)
                    ocmux_pkg::OCMUX_ADDR: begin
                        drive_low_reg <= byte_done_reg &&
                                         ocmux_addr_match(shift_reg, own_addr);
                    end
                    ocmux_pkg::OCMUX_ADDR_ACK: begin
                        drive_low_reg <= ocmux_is_read(shift_reg) && !ctrl_reg[7];
                    end
                    ocmux_pkg::OCMUX_WR_DATA: begin
                        drive_low_reg <= byte_done_reg;
                    end
                    ocmux_pkg::OCMUX_RD_DATA: begin
                        drive_low_reg <= !byte_done_reg && !shift_reg[6];
                    end
                    ocmux_pkg::OCMUX_RD_ACK: begin
                        drive_low_reg <= !rd_nack_reg && !ctrl_reg[7];
                    end
                    default: begin
                        drive_low_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // control byte: each completed write byte overwrites it
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_reg <= `OCMUX_CTRL_RESET;
            pending_reg <= 1'b0;
        end else if (CE) begin
            if (scl_fall && byte_done_reg && state_reg == ocmux_pkg::OCMUX_WR_DATA) begin
                ctrl_reg <= shift_reg;
                pending_reg <= 1'b1;
            end else if (stop_seen) begin
                pending_reg <= 1'b0;
            end
        end
    end

    // applied selection changes only at STOP, when all lines are high
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            applied_reg <= `OCMUX_CTRL_RESET;
        end else if (CE) begin
            if (stop_seen && pending_reg) begin
                applied_reg <= ctrl_reg;
            end
        end
    end

    // upstream pins
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            SDA_O <= 1'b0;
            SDA_OE_N <= 1'b1;
        end else if (CE) begin
            SDA_O <= 1'b0;
            SDA_OE_N <= !drive_low_reg;
        end
    end

    // downstream pairs: a low upstream level is passed to the one chosen pair
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            always_ff @(posedge CLK or negedge RST_N) begin
                if (!RST_N) begin
                    DOWNSTREAM_CLOCK_O[ch] <= 1'b0;
                    DOWNSTREAM_CLOCK_OE_N[ch] <= 1'b1;
                    DOWNSTREAM_DATA_O[ch] <= 1'b0;
                    DOWNSTREAM_DATA_OE_N[ch] <= 1'b1;
                end else if (CE) begin
                    DOWNSTREAM_CLOCK_O[ch] <= 1'b0;
                    DOWNSTREAM_DATA_O[ch] <= 1'b0;
                    // only the low four bits decide
                    if (ocmux_selects(applied_reg, ch)) begin
                        DOWNSTREAM_CLOCK_OE_N[ch] <= scl_sync_reg[1];
                        DOWNSTREAM_DATA_OE_N[ch] <= sda_sync_reg[1];
                    end else begin
                        DOWNSTREAM_CLOCK_OE_N[ch] <= 1'b1;
                        DOWNSTREAM_DATA_OE_N[ch] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

endmodule

/* File: tb/ocmux_top_chk.sv */
// concurrent checks on the pins of the channel multiplexer
`timescale 1ns/1ps
module ocmux_top_chk #(
    parameter int CHANNELS = 8
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic SCL,
    input wire logic SDA_I,
    input wire logic SDA_O,
    input wire logic SDA_OE_N,
    input wire logic [CHANNELS-1:0] DOWNSTREAM_CLOCK_O,
    input wire logic [CHANNELS-1:0] DOWNSTREAM_CLOCK_OE_N,
    input wire logic [CHANNELS-1:0] DOWNSTREAM_DATA_O,
    input wire logic [CHANNELS-1:0] DOWNSTREAM_DATA_OE_N
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    property p_one_clk;
        $onehot0(~DOWNSTREAM_CLOCK_OE_N);
    endproperty
    a_one_clk: assert property (p_one_clk) else $error("two clock pairs bridged");
    property p_one_dat;
        $onehot0(~DOWNSTREAM_DATA_OE_N);
    endproperty
    a_one_dat: assert property (p_one_dat) else $error("two data pairs bridged");
    property p_rst_ch0;
        $rose(RST_N) |-> SDA_OE_N && (&DOWNSTREAM_CLOCK_OE_N[CHANNELS-1:1])
            && (&DOWNSTREAM_DATA_OE_N[CHANNELS-1:1]);
    endproperty
    a_rst_ch0: assert property (p_rst_ch0) else $error("pair other than 0 after reset");
    property p_no_jump;
        (DOWNSTREAM_CLOCK_OE_N != '1 && $past(DOWNSTREAM_CLOCK_OE_N) != '1)
            |-> DOWNSTREAM_CLOCK_OE_N == $past(DOWNSTREAM_CLOCK_OE_N);
    endproperty
    a_no_jump: assert property (p_no_jump) else $error("selection moved mid-transfer");
    property p_clk_fwd;
        DOWNSTREAM_CLOCK_OE_N != '1 |-> !(&{$past(SCL, 1), $past(SCL, 2), $past(SCL, 3),
            $past(SCL, 4), $past(SCL, 5)});
    endproperty
    a_clk_fwd: assert property (p_clk_fwd) else $error("clock pulled without cause");
    property p_dat_fwd;
        DOWNSTREAM_DATA_OE_N != '1 |-> !(&{$past(SDA_I, 1), $past(SDA_I, 2), $past(SDA_I, 3),
            $past(SDA_I, 4), $past(SDA_I, 5)});
    endproperty
    a_dat_fwd: assert property (p_dat_fwd) else $error("data pulled without cause");
    property p_drive_zero;
        !SDA_O && DOWNSTREAM_CLOCK_O == '0 && DOWNSTREAM_DATA_O == '0;
    endproperty
    a_drive_zero: assert property (p_drive_zero) else $error("output level not low");
    property p_ack_hold;
        $fell(SDA_OE_N) |=> !SDA_OE_N [*3];
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("data drive too short");
    property p_chg_low;
        $changed(SDA_OE_N) |-> !SCL;
    endproperty
    a_chg_low: assert property (p_chg_low) else $error("data drive moved, clock high");
    c_ack: cover property ($fell(SDA_OE_N));
    c_last: cover property (!DOWNSTREAM_CLOCK_OE_N[CHANNELS-1]);
    c_rst: cover property ($rose(RST_N));
endmodule

bind ocmux_top ocmux_top_chk #(.CHANNELS(CHANNELS)) i_ocmux_top_chk (
    .CLK(CLK), .RST_N(RST_N), .SCL(SCL), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_N(SDA_OE_N),
    .DOWNSTREAM_CLOCK_O(DOWNSTREAM_CLOCK_O), .DOWNSTREAM_CLOCK_OE_N(DOWNSTREAM_CLOCK_OE_N),
    .DOWNSTREAM_DATA_O(DOWNSTREAM_DATA_O), .DOWNSTREAM_DATA_OE_N(DOWNSTREAM_DATA_OE_N));

/* File: tb/ocmux_master.sv */
// upstream two-wire master model driving the serial clock and data lines
`timescale 1ns/1ps
module ocmux_master (
    output logic scl,
    output logic sda_drv,
    input wire logic sda_in
);
    int q = 653;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // data moves only while the clock is low, except at START and STOP; each phase over 600 ns
    task automatic start();
        sda_drv = 1'b1;
        #q scl = 1'b1;
        #q sda_drv = 1'b0;
        #q scl = 1'b0;
    endtask
    task automatic bit_io(input logic b, output logic r);
        #q sda_drv = b;
        #q scl = 1'b1;
        #q r = sda_in;
        #q scl = 1'b0;
    endtask
    // msb first, then the ninth acknowledge bit
    task automatic byte_io(input logic [7:0] d, input logic ai, output logic [7:0] r,
                           output logic ao);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(ai, ao);
    endtask
    task automatic stop();
        #q sda_drv = 1'b0;
        #q scl = 1'b1;
        #q sda_drv = 1'b1;
        #q;
    endtask
endmodule

/* File: tb/ocmux_top_tb.sv */
// self-checking bench for the channel multiplexer
`timescale 1ns/1ps
module ocmux_top_tb;
    localparam logic [3:0] ADDR_HI = 4'h5;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] strap = 3'h2;
    logic scl, sda_drv, sda_line, sda_o, sda_oe_n, a;
    logic [7:0] ck_o, ck_oe_n, dt_o, dt_oe_n, up, r;
    logic [7:0] wq[$];
    int seed = 32'hef49_45c2;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int model_ctrl = 8'h08;
    int model_applied = 8'h08;
    always #50 clk = ~clk;
    // open-drain line with pull-up
    assign sda_line = sda_drv & (sda_oe_n | sda_o);
    ocmux_master i_ocmux_master (.scl(scl), .sda_drv(sda_drv), .sda_in(sda_line));
    ocmux_top #(.ADDR_HI(ADDR_HI), .CHANNELS(8)) i_ocmux_top (
        .CLK(clk), .RST_N(rst_n), .CE(1'b1), .SCL(scl), .SDA_I(sda_line), .SDA_O(sda_o),
        .SDA_OE_N(sda_oe_n), .ADDR_STRAP_BIT0(strap[0]), .ADDR_STRAP_BIT1(strap[1]),
        .ADDR_STRAP_BIT2(strap[2]), .DOWNSTREAM_CLOCK_O(ck_o), .DOWNSTREAM_CLOCK_OE_N(ck_oe_n),
        .DOWNSTREAM_DATA_O(dt_o), .DOWNSTREAM_DATA_OE_N(dt_oe_n));
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] exp_mask(input int c);
        return c[3] ? ~(8'h01 << c[2:0]) : 8'hff;
    endfunction
    task automatic probe();
        i_ocmux_master.start();
        #600;
        check(ck_oe_n, exp_mask(model_applied));
        check(dt_oe_n, exp_mask(model_applied));
        check(ck_o | dt_o, 8'h00);
        i_ocmux_master.stop();
    endtask
    task automatic write_txn();
        i_ocmux_master.start();
        i_ocmux_master.byte_io({ADDR_HI, strap, 1'b0}, 1'b1, r, a);
        check(a, 1'b0);
        foreach (wq[i]) begin
            i_ocmux_master.byte_io(wq[i], 1'b1, r, a);
            check(a, 1'b0);
        end
        model_ctrl = wq[wq.size()-1];
        #600;
        check(ck_oe_n, exp_mask(model_applied));
        i_ocmux_master.stop();
        model_applied = model_ctrl;
    endtask
    task automatic read_txn();
        i_ocmux_master.start();
        i_ocmux_master.byte_io({ADDR_HI, strap, 1'b1}, 1'b1, r, a);
        check(a, 1'b0);
        i_ocmux_master.byte_io(8'hff, 1'b0, r, a);
        check(r, model_ctrl[7:0]);
        i_ocmux_master.byte_io(8'hff, 1'b1, r, a);
        check(r, model_ctrl[7:0]);
        i_ocmux_master.stop();
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        probe();
        read_txn();
        $display("power-up test done");
        for (int c = 0; c < 16; c++) begin
            up = 8'($random(seed));
            i_ocmux_master.q = c[0] ? 907 : 653;
            wq = '{{up[7:4], c[3:0]}};
            write_txn();
            probe();
            read_txn();
        end
        $display("control codes test done");
        wq = '{8'h0f, 8'h3a, 8'h09};
        write_txn();
        probe();
        i_ocmux_master.start();
        i_ocmux_master.byte_io({ADDR_HI, strap, 1'b0}, 1'b1, r, a);
        check(a, 1'b0);
        i_ocmux_master.byte_io(8'h0b, 1'b1, r, a);
        check(a, 1'b0);
        model_ctrl = 8'h0b;
        probe();
        model_applied = model_ctrl;
        probe();
        read_txn();
        $display("multi-byte test done");
        up = 8'($random(seed));
        @(negedge clk);
        strap = up[2:0];
        repeat (4) @(negedge clk);
        i_ocmux_master.start();
        i_ocmux_master.byte_io({ADDR_HI, ~strap, 1'b0}, 1'b1, r, a);
        check(a, 1'b1);
        i_ocmux_master.stop();
        wq = '{8'h0e};
        write_txn();
        probe();
        $display("address test done");
        wq = '{8'hfd};
        write_txn();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        model_ctrl = 8'h08;
        model_applied = 8'h08;
        repeat (4) @(negedge clk);
        probe();
        read_txn();
        $display("reset test done");
        stop_test();
    end
endmodule
